// ### hw/adc_channel_config_regs.sv
// Configuration register bank of a four-channel delta-sigma converter
//
// What this block does
// - Channel 0 gain code 2:0 selects gain two to the code, reset 000b.
// - Index 5h is a spare 16-bit read-write word, reset zero, no effect.
// - Chop delay 12:9 waits 2^(code+1) modulator periods, reset 0011b.
// - Bit 8 enables global chop; reset disabled.
// - Bit 7 clear: any channel over threshold; set: all channels.
// - Bits 6:4 set needed exceedances, two to the code.
// - Bits 3:1 pick measurement length 128 to 3584 conversions.
// - Bit 0 enables current-detect mode; reset disabled.
// - Threshold upper 16 bits at 7h, lower byte 15:8 at 8h, reset zero.
// - Bits 3:0 at 8h hold DC-block setting; bits 7:4 read zero.
// - Bits 15:6 at 9h hold channel 0 phase delay; 5:3 read-only.
// - Bit 2 at 9h set bypasses DC-block for channel 0 only.
// - Bits 1:0 at 9h route channel 0 inputs: pair, short, +DC, -DC.
// - Offset calibration is 24 bits: Ah word high, low byte from the chan0_offset_low input.
//
// Our own choice: the APB slave port.

`include "adc_cfg_regs.svh"

module adc_channel_config_regs
  import adc_cfg_pkg::*;
#(
  parameter int AW  = 8,
  parameter int NCH = 4,
  parameter int DW  = 24
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [AW-1:0]     paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              mod_clk_en,
  input  wire logic              meas_req,
  input  wire logic              conv_valid,
  input  wire logic [NCH*DW-1:0] conv_data,
  input  wire logic [7:0]        chan0_offset_low,
  output logic      [2:0]        chan0_gain_code,
  output logic      [7:0]        chan0_gain_factor,
  output logic                   chop_enable,
  output logic      [3:0]        chop_settle_delay,
  output logic                   measure_go,
  output logic                   detect_mode_enable,
  output logic                   detect_all_channels,
  output logic      [2:0]        detect_exceed_count,
  output logic      [2:0]        detect_measure_length,
  output logic      [DW-1:0]     detect_threshold,
  output logic                   detect_pulse,
  output logic                   detect_flag,
  output logic      [3:0]        dc_removal_setting,
  output logic      [9:0]        chan0_phase_delay,
  output logic                   chan0_dc_removal_off,
  output logic      [1:0]        chan0_input_select,
  output logic      [DW-1:0]     chan0_offset
);

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  reg_word_t   gain_r;
  reg_word_t   spare_r;
  reg_word_t   cfg_r;
  reg_word_t   thr_hi_r;
  logic [7:0]  thr_lo_r;
  logic [3:0]  dcb_r;
  logic [9:0]  phase_r;
  logic        dcoff_r;
  logic [1:0]  mux_r;
  reg_word_t   ocal_hi_r;
  logic        det_flag_r;
  chop_state_t chop_st;

  logic [5:0]  idx;
  logic        aligned;
  logic        mapped;
  logic        setup_ph;
  logic        wr_acc;
  logic        det_clr;
  logic        det_set;
  reg_word_t   rd_word;

  assign idx      = paddr[7:2];
  assign aligned  = (paddr[1:0] == 2'b00);
  assign setup_ph = psel && !penable;
  assign wr_acc   = psel && penable && pready && pwrite && aligned;

  // --------------------------------------------------------------------
  // Address decode and read mux
  // --------------------------------------------------------------------
  always_comb begin
    mapped  = 1'b1;
    rd_word = `RST_ZERO;
    if (idx == `IDX_GAIN) begin
      rd_word = gain_r;
    end else if (idx == `IDX_SPARE) begin
      rd_word = spare_r;
    end else if (idx == `IDX_CFG) begin
      rd_word = cfg_r;
    end else if (idx == `IDX_THR_HI) begin
      rd_word = thr_hi_r;
    end else if (idx == `IDX_THR_LO) begin
      // Bits 7:4 stay zero
      rd_word[`THR_LO_HI:`THR_LO_LO] = thr_lo_r;
      rd_word[`DCB_HI:`DCB_LO]       = dcb_r;
    end else if (idx == `IDX_CH0) begin
      rd_word[`PHASE_HI:`PHASE_LO] = phase_r;
      rd_word[`DCOFF_BIT]          = dcoff_r;
      rd_word[`MUX_HI:`MUX_LO]     = mux_r;
    end else if (idx == `IDX_OCAL_HI) begin
      rd_word = ocal_hi_r;
    end else if (idx == `IDX_STATUS) begin
      rd_word[`STAT_DET_BIT]  = det_flag_r;
      rd_word[`STAT_WAIT_BIT] = (chop_st == CHOP_WAIT);
    end else begin
      mapped = 1'b0;
    end
    if (!aligned) begin
      mapped = 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // APB answer: one wait-free access phase
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_ph;
      if (setup_ph) begin
        pslverr <= !mapped;
        prdata  <= (mapped && !pwrite) ? {16'h0000, rd_word} : 32'h0;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gain_r    <= `RST_ZERO;
      spare_r   <= `RST_ZERO;
      cfg_r     <= `RST_CFG;
      thr_hi_r  <= `RST_ZERO;
      thr_lo_r  <= 8'h00;
      dcb_r     <= 4'h0;
      phase_r   <= 10'h000;
      dcoff_r   <= 1'b0;
      mux_r     <= 2'b00;
      ocal_hi_r <= `RST_ZERO;
    end else if (wr_acc) begin
      if (idx == `IDX_GAIN) begin
        gain_r <= pwdata[15:0];
      end else if (idx == `IDX_SPARE) begin
        spare_r <= pwdata[15:0];
      end else if (idx == `IDX_CFG) begin
        cfg_r <= pwdata[15:0];
      end else if (idx == `IDX_THR_HI) begin
        thr_hi_r <= pwdata[15:0];
      end else if (idx == `IDX_THR_LO) begin
        thr_lo_r <= pwdata[`THR_LO_HI:`THR_LO_LO];
        dcb_r    <= pwdata[`DCB_HI:`DCB_LO];
      end else if (idx == `IDX_CH0) begin
        phase_r <= pwdata[`PHASE_HI:`PHASE_LO];
        dcoff_r <= pwdata[`DCOFF_BIT];
        mux_r   <= pwdata[`MUX_HI:`MUX_LO];
      end else if (idx == `IDX_OCAL_HI) begin
        ocal_hi_r <= pwdata[15:0];
      end
    end
  end

  assign det_clr = wr_acc && (idx == `IDX_STATUS) &&
                   pwdata[`STAT_DET_BIT];

  // --------------------------------------------------------------------
  // Field outputs, all from flops
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chan0_gain_code       <= 3'b000;
      chan0_gain_factor     <= 8'h01;
      chop_enable           <= 1'b0;
      chop_settle_delay     <= 4'(`RST_CFG >> `DLY_LO);
      detect_mode_enable    <= 1'b0;
      detect_all_channels   <= 1'b0;
      detect_exceed_count   <= 3'b000;
      detect_measure_length <= 3'b000;
      detect_threshold      <= '0;
      dc_removal_setting    <= 4'h0;
      chan0_phase_delay     <= 10'h000;
      chan0_dc_removal_off  <= 1'b0;
      chan0_input_select    <= 2'b00;
      chan0_offset          <= '0;
    end else begin
      chan0_gain_code       <= gain_r[`GAIN0_HI:`GAIN0_LO];
      chan0_gain_factor     <= 8'h01 << gain_r[`GAIN0_HI:`GAIN0_LO];
      chop_enable           <= cfg_r[`CHOP_EN_BIT];
      chop_settle_delay     <= cfg_r[`DLY_HI:`DLY_LO];
      detect_mode_enable    <= cfg_r[`DET_EN_BIT];
      detect_all_channels   <= cfg_r[`ALLCH_BIT];
      detect_exceed_count   <= cfg_r[`NUM_HI:`NUM_LO];
      detect_measure_length <= cfg_r[`LEN_HI:`LEN_LO];
      detect_threshold      <= {thr_hi_r, thr_lo_r};
      dc_removal_setting    <= dcb_r;
      chan0_phase_delay     <= phase_r;
      chan0_dc_removal_off  <= dcoff_r;
      chan0_input_select    <= mux_r;
      chan0_offset          <= {ocal_hi_r, chan0_offset_low};
    end
  end

  // --------------------------------------------------------------------
  // Global-chop settling delay
  // --------------------------------------------------------------------
  logic [16:0] chop_cnt_r;
  logic [16:0] chop_target;

  // Up to 65536 periods; counter sized for the largest code
  assign chop_target = 17'h00001 << ({1'b0, cfg_r[`DLY_HI:`DLY_LO]} +
                                     5'd1);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chop_st    <= CHOP_IDLE;
      chop_cnt_r <= 17'h00000;
      measure_go <= 1'b0;
    end else begin
      measure_go <= 1'b0;
      case (chop_st)
        CHOP_IDLE: begin
          chop_cnt_r <= 17'h00000;
          if (meas_req && cfg_r[`CHOP_EN_BIT]) begin
            chop_st <= CHOP_WAIT;
          end else if (meas_req) begin
            measure_go <= 1'b1;
          end
        end
        CHOP_WAIT: begin
          if (mod_clk_en) begin
            if (chop_cnt_r == chop_target - 17'h00001) begin
              measure_go <= 1'b1;
              chop_st    <= CHOP_IDLE;
            end else begin
              chop_cnt_r <= chop_cnt_r + 17'h00001;
            end
          end
        end
        default: begin
          chop_st <= CHOP_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Current detect
  // --------------------------------------------------------------------
  logic [NCH-1:0] over;
  logic           hit;
  logic [7:0]     hit_cnt_r;
  logic [11:0]    conv_cnt_r;
  logic [11:0]    len_conv;
  logic [7:0]     need;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_cmp
      logic [DW-1:0] s;
      logic [DW-1:0] mag;
      assign s   = conv_data[g*DW +: DW];
      assign mag = s[DW-1] ? (~s + 1'b1) : s;
      assign over[g] = (mag > {thr_hi_r, thr_lo_r});
    end
  endgenerate

  assign hit  = cfg_r[`ALLCH_BIT] ? (&over) : (|over);
  assign need = 8'h01 << cfg_r[`NUM_HI:`NUM_LO];

  always_comb begin
    case (cfg_r[`LEN_HI:`LEN_LO])
      3'd0:    len_conv = `LEN_C0;
      3'd1:    len_conv = `LEN_C1;
      3'd2:    len_conv = `LEN_C2;
      3'd3:    len_conv = `LEN_C3;
      3'd4:    len_conv = `LEN_C4;
      3'd5:    len_conv = `LEN_C5;
      3'd6:    len_conv = `LEN_C6;
      default: len_conv = `LEN_C7;
    endcase
  end

  // One detection per window; counts restart each window
  assign det_set = cfg_r[`DET_EN_BIT] && conv_valid && hit &&
                   (hit_cnt_r == need - 8'h01);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hit_cnt_r  <= 8'h00;
      conv_cnt_r <= 12'h000;
    end else if (!cfg_r[`DET_EN_BIT]) begin
      hit_cnt_r  <= 8'h00;
      conv_cnt_r <= 12'h000;
    end else if (conv_valid) begin
      if (conv_cnt_r == len_conv - 12'h001) begin
        conv_cnt_r <= 12'h000;
        hit_cnt_r  <= 8'h00;
      end else begin
        conv_cnt_r <= conv_cnt_r + 12'h001;
        if (hit && hit_cnt_r != 8'hFF) begin
          hit_cnt_r <= hit_cnt_r + 8'h01;
        end
      end
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      det_flag_r   <= 1'b0;
      detect_pulse <= 1'b0;
      detect_flag  <= 1'b0;
    end else begin
      detect_pulse <= det_set;
      if (det_set) begin
        det_flag_r <= 1'b1;
      end else if (det_clr) begin
        det_flag_r <= 1'b0;
      end
      detect_flag <= det_flag_r;
    end
  end

endmodule

// ### shared/adc_cfg_pkg.sv
// Types shared by the converter configuration bank
package adc_cfg_pkg;

  typedef enum logic [0:0] {
    CHOP_IDLE = 1'b0,
    CHOP_WAIT = 1'b1
  } chop_state_t;

  typedef logic [15:0] reg_word_t;

endpackage

// ### shared/adc_cfg_regs.svh
// Register indices, field positions and reset values of the config bank
`ifndef ADC_CFG_REGS_SVH
`define ADC_CFG_REGS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_GAIN      6'h04
`define IDX_SPARE     6'h05
`define IDX_CFG       6'h06
`define IDX_THR_HI    6'h07
`define IDX_THR_LO    6'h08
`define IDX_CH0       6'h09
`define IDX_OCAL_HI   6'h0A
`define IDX_STATUS    6'h1F

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_ZERO      16'h0000
`define RST_CFG       16'h0600

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define GAIN0_HI      2
`define GAIN0_LO      0
`define DLY_HI        12
`define DLY_LO        9
`define CHOP_EN_BIT   8
`define ALLCH_BIT     7
`define NUM_HI        6
`define NUM_LO        4
`define LEN_HI        3
`define LEN_LO        1
`define DET_EN_BIT    0
`define THR_LO_HI     15
`define THR_LO_LO     8
`define DCB_HI        3
`define DCB_LO        0
`define PHASE_HI      15
`define PHASE_LO      6
`define DCOFF_BIT     2
`define MUX_HI        1
`define MUX_LO        0
`define STAT_DET_BIT  0
`define STAT_WAIT_BIT 1

// ----------------------------------------------------------------------
// Measurement lengths in conversion periods
// ----------------------------------------------------------------------
`define LEN_C0        12'd128
`define LEN_C1        12'd256
`define LEN_C2        12'd512
`define LEN_C3        12'd768
`define LEN_C4        12'd1280
`define LEN_C5        12'd1792
`define LEN_C6        12'd2560
`define LEN_C7        12'd3584

`endif

// ### testbench/adc_cfg_assertions.sv
// Port-level checks on the converter configuration bank
module adc_cfg_assertions (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        meas_req,
  input wire logic        chop_enable,
  input wire logic        measure_go,
  input wire logic        detect_pulse,
  input wire logic        detect_flag,
  input wire logic [2:0]  chan0_gain_code,
  input wire logic [7:0]  chan0_gain_factor
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_ready_next;
    psel && !penable |=> pready;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("pready late");
  property p_ready_one;
    pready |=> !pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("pready held");
  property p_err_zero;
    pready && pslverr |-> prdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error data");
  // Two stable cycles cover the copy lag
  property p_gain;
    $stable(chan0_gain_code) [*2] |->
      chan0_gain_factor == (8'h01 << chan0_gain_code);
  endproperty
  a_gain: assert property (p_gain) else $error("gain factor");
  // Copy lags a cycle; next cycle shows the bit in use
  property p_go_free;
    meas_req && !chop_enable ##1 !chop_enable |-> measure_go;
  endproperty
  a_go_free: assert property (p_go_free) else $error("no go");
  property p_go_one;
    measure_go |=> !measure_go;
  endproperty
  a_go_one: assert property (p_go_one) else $error("go held");
  property p_go_cause;
    measure_go && !chop_enable |-> $past(meas_req);
  endproperty
  a_go_cause: assert property (p_go_cause) else $error("stray go");
  property p_flag;
    detect_pulse |=> detect_flag;
  endproperty
  a_flag: assert property (p_flag) else $error("flag missing");
endmodule

bind adc_channel_config_regs adc_cfg_assertions u_chk (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .meas_req(meas_req), .chop_enable(chop_enable),
  .measure_go(measure_go), .detect_pulse(detect_pulse),
  .detect_flag(detect_flag), .chan0_gain_code(chan0_gain_code),
  .chan0_gain_factor(chan0_gain_factor)
);

// ### testbench/apb_host.sv
// Register bus host model
module apb_host (
  input  wire logic        ref_clk,
  output logic             psel    = 1'b0,
  output logic             penable = 1'b0,
  output logic             pwrite  = 1'b0,
  output logic [7:0]       paddr   = 8'h00,
  output logic [31:0]      pwdata  = 32'h0,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  int tmo = 0;
  // ----
  // Transfer
  // ----
  // Request held until pready seen at an edge
  task automatic xfer(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) tmo++;
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ### testbench/testbench.sv
// Self-checking bench for the converter configuration bank
`include "adc_cfg_regs.svh"
module testbench import adc_cfg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'b0, rst = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr, gfac, ofs = 8'hEF;
  logic [31:0] pwdata, prdata, q;
  logic        men = 1'b1, req = 1'b0, cv = 1'b0;
  logic [95:0] cd = '0;
  logic [2:0]  gc, dnum, dlen;
  logic        chop, go, den, dall, dp, df, dco;
  logic [3:0]  cdly, dcb;
  logic [23:0] thr, ocal;
  logic [9:0]  ph;
  logic [1:0]  mux;
  logic [5:0]  ri [7] = '{6'h4, 6'h5, 6'h6, 6'h7, 6'h8, 6'h9, 6'hA};
  logic [15:0] rm [7] = '{'1, '1, '1, '1, 16'hFF0F, 16'hFFC7, '1};
  logic [15:0] p;
  int          errors = 0, n_checks = 0, t0, t1, t3, h;
  initial forever #5 ref_clk = ~ref_clk;
  adc_channel_config_regs u_dut (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mod_clk_en(men),
    .meas_req(req), .conv_valid(cv), .conv_data(cd),
    .chan0_offset_low(ofs), .chan0_gain_code(gc),
    .chan0_gain_factor(gfac), .chop_enable(chop),
    .chop_settle_delay(cdly), .measure_go(go),
    .detect_mode_enable(den), .detect_all_channels(dall),
    .detect_exceed_count(dnum), .detect_measure_length(dlen),
    .detect_threshold(thr), .detect_pulse(dp), .detect_flag(df),
    .dc_removal_setting(dcb), .chan0_phase_delay(ph),
    .chan0_dc_removal_off(dco), .chan0_input_select(mux),
    .chan0_offset(ocal));
  apb_host u_host (
    .ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  // ----
  // Tasks
  // ----
  task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", nm, ex, got);
    end
  endtask
  task automatic wr(logic [5:0] i, logic [15:0] d);
    u_host.xfer(1'b1, {i, 2'b00}, {16'h0, d}, q, e);
    if (u_host.tmo != 0) complete_run();
  endtask
  task automatic rd(logic [5:0] i, logic [15:0] ex);
    u_host.xfer(1'b0, {i, 2'b00}, 32'h0, q, e);
    if (u_host.tmo != 0) complete_run();
    chk("read", {16'h0, ex}, q);
  endtask
  // Field copies lag the register by a clock
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic complete_run;
    errors += u_host.tmo;
    if (errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Pulse window is four cycles; spaced valids keep pulses apart
  task automatic conv(logic [23:0] v, logic [23:0] w, output int n);
    @(posedge ref_clk);
    cv <= 1'b1;
    cd <= {w, w, w, v};
    @(posedge ref_clk);
    cv <= 1'b0;
    n = 0;
    repeat (4) begin
      #1;
      n += (dp === 1'b1);
      @(posedge ref_clk);
    end
  endtask
  task automatic go_time(logic [15:0] c, output int n);
    wr(`IDX_CFG, c);
    settle();
    @(posedge ref_clk);
    req <= 1'b1;
    @(posedge ref_clk);
    req <= 1'b0;
    n = 0;
    while (go !== 1'b1 && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 300) begin
      errors++;
      complete_run();
    end
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk("gain_factor", 8'h01, gfac);
    chk("chop_delay", 4'h3, cdly);
    for (int i = 0; i < 7; i++) rd(ri[i], i == 2 ? 16'h0600 : 16'h0);
    rd(`IDX_STATUS, 16'h0);
    foreach (rm[i]) begin
      p = i[0] ? 16'h5A5B : 16'hA5A4;
      for (int j = 0; j < 7; j++) wr(ri[j], p);
      settle();
      for (int j = 0; j < 7; j++) rd(ri[j], p & rm[j]);
      chk("cfg", p & 16'h1FFF, {cdly, chop, dall, dnum, dlen, den});
      chk("thr", {p, p[15:8]}, thr);
      chk("ch0", p & 16'hFFC7, {ph, 3'b0, dco, mux});
      chk("dcb", p[3:0], dcb);
      chk("ocal", {p, ofs}, ocal);
    end
    for (int k = 0; k < 8; k++) begin
      wr(`IDX_GAIN, 16'(k));
      settle();
      chk("gain", 8'h01 << k, gfac);
      chk("gain_code", k, gc);
    end
    u_host.xfer(1'b1, 8'h40, 32'hFFFF, q, e);
    chk("unmapped", 1'b1, e);
    u_host.xfer(1'b0, 8'h19, 32'h0, q, e);
    chk("unaligned_err", 1'b1, e);
    chk("unaligned_data", 32'h0, q);
    go_time(16'h0000, h);
    chk("chop_off", 1, h);
    go_time(16'h0100, t0);
    go_time(16'h0300, t1);
    go_time(16'h0700, t3);
    chk("chop_step", 2, t1 - t0);
    chk("chop_16", 14, t3 - t0);
    wr(`IDX_THR_HI, 16'h0);
    wr(`IDX_THR_LO, 16'h1000);
    wr(`IDX_CFG, 16'h0011);
    settle();
    conv(24'h10, 24'h0, h);
    chk("det_equal", 0, h);
    conv(24'h20, 24'h0, h);
    chk("det_first", 0, h);
    conv(24'hFFFFE0, 24'h0, h);
    chk("det_second", 1, h);
    chk("det_flag", 1, df);
    rd(`IDX_STATUS, 16'h1);
    wr(`IDX_STATUS, 16'h1);
    rd(`IDX_STATUS, 16'h0);
    chk("flag_clear", 0, df);
    wr(`IDX_CFG, 16'h0);
    settle();
    conv(24'h20, 24'h20, h);
    chk("det_off", 0, h);
    wr(`IDX_CFG, 16'h0081);
    settle();
    conv(24'h20, 24'h0, h);
    chk("det_one", 0, h);
    conv(24'h20, 24'h20, h);
    chk("det_all", 1, h);
    complete_run();
  end
endmodule
